// ### design/wit_defines.svh
`ifndef WIT_DEFINES_SVH
`define WIT_DEFINES_SVH

// ****************************************************************
// Register map (Avalon byte addresses, index times four)
// ****************************************************************
`define WIT_CTL_INDEX 12'h00C9
`define WIT_STAT_INDEX 12'h00CA
`define WIT_CTL_ADDR 12'h0324
`define WIT_STAT_ADDR 12'h0328

// ****************************************************************
// Control field positions and reset values
// ****************************************************************
`define WIT_KEY_MSB 7
`define WIT_KEY_LSB 4
`define WIT_EN_BIT 3
`define WIT_MODE_BIT 2
`define WIT_INT_MSB 1
`define WIT_INT_LSB 0
`define WIT_CTL_RESET 8'h00
`define WIT_KEY_FIRST 4'hA
`define WIT_KEY_SECOND 4'h5
`define WIT_CAUSE_POR 2'b00
`define WIT_CAUSE_WDOG 2'b10

// ****************************************************************
// Terminal counts, each stored as count minus one
// ****************************************************************
`define WIT_LIM_32768 15'h7FFF
`define WIT_LIM_8192 15'h1FFF
`define WIT_LIM_512 15'h01FF
`define WIT_LIM_64 15'h003F

// ****************************************************************
// Timing
// ****************************************************************
`define WIT_CLK_PERIOD_NS 50
`define WIT_SLOW_PERIOD_NS 30518
`define WIT_SLOW_DIV (`WIT_SLOW_PERIOD_NS / `WIT_CLK_PERIOD_NS)
`define WIT_KEY_WIN ((`WIT_SLOW_PERIOD_NS / 2) / `WIT_CLK_PERIOD_NS)
`define WIT_RST_PULSE 4

`endif

// ### design/wit_pkg.sv
package wit_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic {WIT_KEY_IDLE, WIT_KEY_ARMED} wit_key_e;

   typedef struct packed {
      logic en;
      logic mode;
      logic [1:0] intv;
      logic [14:0] cnt;
      logic pend;
      logic [11:0] div;
      wit_key_e key;
      logic [11:0] ktmr;
      logic [2:0] rst_cnt;
      logic rst_req;
      logic irq;
      logic [1:0] cause;
      logic rd_done;
      logic [31:0] rdata;
   } wit_state_s;

   typedef logic [11:0] wit_addr_t;

endpackage

// ### design/wit_top.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`include "wit_defines.svh"
// How it works
// [R1] Hidden 15-bit up-counter advances on the slow oscillator tick only.
// [R2] Any reset leaves the timer disabled with its counter stopped.
// [R3] Control bit 2 picks watchdog (0) or interval timer (1).
// [R4] Writing run bit 1 starts counting in either function.
// [R5] Once running as watchdog, writing run bit 0 is ignored.
// [R6] Function select is frozen while the watchdog runs.
// [R7] Interval field picks 32768, 8192, 512 or 64 slow periods.
// [R8] Watchdog reaching terminal count requests a system reset.
// [R9] Key 0xA then 0x5 within half a slow period reloads zero.
// [R10] Incomplete or wrong key pair does not reload; expiry still resets.
// [R11] Pair started in time reloads even if completed after the boundary.
// [R12] Interval field stays writable while the watchdog runs.
// [R13] Software should key-clear whenever it changes the interval.
// [R14] Watchdog function never raises the timer interrupt.
// [R15] Interval timer raises an interrupt at each terminal count.
// [R16] Timer function: key field bit 0 set clears counter directly.
// [R17] Timer function: run 0 halts, run 1 restarts from zero.
// [R18] Timer function never requests a system reset.
// [R19] Key field writes while stopped do nothing.
// [R20] Key field always reads back as zero.
// [R21] Watchdog reset records cause code 10, replacing older cause.
// [R22] Timer restarts from zero after terminal count and keeps going.
// [R23] Slow-domain events run on the bus clock through a tick enable, so nothing crosses.
module wit_top
#(
   parameter int SLOW_DIV = `WIT_SLOW_DIV,
   parameter int KEY_WIN = `WIT_KEY_WIN,
   parameter int RST_PULSE = `WIT_RST_PULSE
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Avalon-MM slave
   input wire wit_pkg::wit_addr_t ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   output logic [31:0] READDATA,
   output logic WAITREQUEST,
   // System requests
   output logic SYS_RST_REQ,
   output logic TIMER_IRQ,
   output logic [1:0] RST_CAUSE
);
   import wit_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Divider and key window live in 12-bit fields
   if (SLOW_DIV < 2 || SLOW_DIV > 4096 || KEY_WIN < 1 || KEY_WIN >= SLOW_DIV ||
       RST_PULSE < 1 || RST_PULSE > 7) begin : g_bad_param
      $error("wit_top: unsupported parameter value");
   end

   // Load values cut to the widths of their state fields
   localparam logic [11:0] DIV_LAST = 12'(SLOW_DIV - 1);
   localparam logic [11:0] KEY_LOAD = 12'(KEY_WIN);
   localparam logic [2:0] RST_LOAD = 3'(RST_PULSE);

   // ****************************************************************
   // State
   // ****************************************************************
   wit_state_s q;
   wit_state_s s;
   logic tick;
   logic [14:0] lim;
   logic ctl_wr;
   logic wd_run;
   logic [7:0] wbyte;
   logic [3:0] nib;

   // Terminal count minus one for an interval code
   function automatic logic [14:0] lim_of(input logic [1:0] code);
      logic [14:0] r;
      r = `WIT_LIM_32768;
      unique case (code)
         2'b00: r = `WIT_LIM_32768;
         2'b01: r = `WIT_LIM_8192;
         2'b10: r = `WIT_LIM_512;
         2'b11: r = `WIT_LIM_64;
      endcase
      return r;
   endfunction

   // Decode shared by next-state logic and checks
   always_comb begin
      tick = (q.div == DIV_LAST);
      lim = lim_of(q.intv); // R7
      ctl_wr = WRITE && (ADDRESS == `WIT_CTL_ADDR);
      wd_run = q.en && !q.mode;
      wbyte = WRITEDATA[7:0];
      nib = wbyte[`WIT_KEY_MSB:`WIT_KEY_LSB];
   end

   // Writes never stall; reads stall one cycle so data comes from flops
   // Stalling reads costs a cycle but keeps READDATA glitch free
   assign WAITREQUEST = READ && !q.rd_done;
   assign READDATA = q.rdata;
   assign SYS_RST_REQ = q.rst_req;
   assign TIMER_IRQ = q.irq;
   assign RST_CAUSE = q.cause;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s = q;
      s.irq = 1'b0;
      s.rd_done = 1'b0;
      // Slow tick divider; one clock, so the slow rate is an enable.
      // Bus writes and events share this clock, so nothing needs crossing.
      s.div = tick ? 12'h000 : q.div + 12'h001; // R23
      if (q.rst_cnt != 3'd0) begin
         s.rst_cnt = q.rst_cnt - 3'd1;
      end
      // Counter advance and terminal handling
      // Pending expiry freezes the count until the pair or reset resolves
      if (q.en && tick && !q.pend) begin
         if (q.cnt >= lim) begin
            if (q.mode) begin
               s.cnt = 15'h0000; // R22
               s.irq = 1'b1; // R15 R14
            end else begin
               s.pend = 1'b1; // R8
            end
         end else begin
            s.cnt = q.cnt + 15'h0001; // R1
         end
      end
      // Key window runs out on its own
      if (q.key == WIT_KEY_ARMED) begin
         if (q.ktmr == 12'h000) begin
            s.key = WIT_KEY_IDLE; // R10
         end else begin
            s.ktmr = q.ktmr - 12'h001;
         end
      end
      // Expiry waits while a pair is in flight, so a late 0x5 still saves it
      // Expiry clears control here so software sees a stopped, reset timer
      if (q.pend && q.key == WIT_KEY_IDLE && !q.mode) begin // R11 R18
         s.en = 1'b0;
         s.mode = 1'b0;
         s.intv = 2'b00;
         s.cnt = 15'h0000;
         s.pend = 1'b0;
         s.rst_cnt = RST_LOAD; // R8
         s.cause = `WIT_CAUSE_WDOG; // R21
      end else if (ctl_wr) begin
         if (!wd_run) begin
            s.mode = wbyte[`WIT_MODE_BIT]; // R3 R6
         end
         s.intv = wbyte[`WIT_INT_MSB:`WIT_INT_LSB]; // R12
         if (wbyte[`WIT_EN_BIT]) begin
            s.en = 1'b1; // R4
            if (!q.en) begin
               s.cnt = 15'h0000; // R17
               s.pend = 1'b0;
            end
         end else if (!wd_run) begin
            s.en = 1'b0; // R5 R17
            s.pend = 1'b0;
         end
         // Key field acts only on a running timer
         // A wrong nibble drops an armed pair, so stray writes cannot half-clear
         if (q.en) begin // R19
            if (!q.mode) begin
               if (q.key == WIT_KEY_ARMED && nib == `WIT_KEY_SECOND) begin
                  s.cnt = 15'h0000; // R9
                  s.pend = 1'b0;
                  s.key = WIT_KEY_IDLE;
               end else if (nib == `WIT_KEY_FIRST) begin
                  s.key = WIT_KEY_ARMED;
                  s.ktmr = KEY_LOAD;
               end else begin
                  s.key = WIT_KEY_IDLE; // R10
               end
            end else if (nib[0]) begin
               s.cnt = 15'h0000; // R16
            end
         end
      end
      // Request follows the pulse counter, so it leaves a flop cleanly
      s.rst_req = (s.rst_cnt != 3'd0);
      // Read answer one cycle after the request
      if (READ && !q.rd_done) begin
         s.rd_done = 1'b1;
         s.rdata = 32'h0000_0000;
         if (ADDRESS == `WIT_CTL_ADDR) begin
            s.rdata[`WIT_EN_BIT] = q.en; // R20
            s.rdata[`WIT_MODE_BIT] = q.mode;
            s.rdata[`WIT_INT_MSB:`WIT_INT_LSB] = q.intv;
         end else if (ADDRESS == `WIT_STAT_ADDR) begin
            s.rdata[1:0] = q.cause;
            s.rdata[2] = q.en;
            s.rdata[3] = q.key == WIT_KEY_ARMED;
         end
      end
   end

   // Single state register; power-on reset sets cause to 00
   // Reset value is all zeros: stopped, watchdog function, longest interval
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '0; // R2
      end else begin
         q <= s;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   // All checks share the bus clock and sleep during reset
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   // Watchdog cannot be stopped by software
   AST_WD_NO_STOP: assert property (wd_run && !q.pend |=> q.en) // R5
      else $error("watchdog stopped by a write");

   // Function bit frozen while watchdog runs
   AST_WD_MODE_LOCK: assert property (wd_run && ctl_wr |=> !q.mode) // R6
      else $error("function changed while watchdog running");

   // No interrupt in watchdog function
   AST_WD_NO_IRQ: assert property (TIMER_IRQ |-> $past(q.mode)) // R14
      else $error("interrupt raised in watchdog function");

   // Timer terminal gives one interrupt and a zeroed counter
   AST_TMR_IRQ: assert property (q.en && q.mode && tick && !q.pend && q.cnt >= lim
      && !ctl_wr |=> TIMER_IRQ && q.cnt == 15'h0000 ##1 !TIMER_IRQ) // R15
      else $error("timer terminal count mishandled");

   // Timer function never resets the system
   AST_TMR_NO_RST: assert property ($rose(SYS_RST_REQ) |-> !$past(q.mode)) // R18
      else $error("reset request in timer function");

   // Expiry gives a reset pulse of fixed length with cause 10
   AST_WD_FIRE: assert property (q.pend && q.key == WIT_KEY_IDLE && !q.mode
      |=> SYS_RST_REQ[*4] ##1 !SYS_RST_REQ) // R8
      else $error("watchdog reset pulse wrong");

   AST_WD_CAUSE: assert property ($rose(SYS_RST_REQ) |-> RST_CAUSE == 2'b10) // R21
      else $error("reset cause not recorded");

   // Second key write inside the window reloads zero
   AST_KEY_CLEAR: assert property (ctl_wr && wd_run && q.key == WIT_KEY_ARMED
      && nib == 4'h5 |=> q.cnt == 15'h0000 && !q.pend) // R9
      else $error("keyed clear did not reload");

   // Pending expiry waits for an armed pair
   AST_KEY_LATE: assert property (q.pend && q.key == WIT_KEY_ARMED |=> !$rose(SYS_RST_REQ)) // R11
      else $error("reset issued during key pair");

   // Stopped timer ignores key writes
   AST_CLR_IGNORED: assert property (ctl_wr && !q.en && !WRITEDATA[3]
      |=> q.cnt == $past(q.cnt)) // R19
      else $error("key write acted while stopped");

   // Key field reads as zero
   AST_KEY_READ_ZERO: assert property (q.rd_done |-> READDATA[7:4] == 4'h0) // R20
      else $error("key field read nonzero");

   // ****************************************************************
   // Counter, key and bus checks
   // ****************************************************************

   // Stopped counter holds; reset leaves it stopped
   AST_STOP_HOLD: assert property (!q.en && !ctl_wr |=> q.cnt == $past(q.cnt)) // R2
      else $error("stopped counter moved");

   // Running counter moves only on a slow tick
   AST_CNT_IDLE: assert property (q.en && !q.pend && !tick && !ctl_wr // R1
      |=> q.cnt == $past(q.cnt))
      else $error("counter moved between ticks");

   // Each tick below the terminal adds exactly one
   AST_CNT_STEP: assert property (q.en && !q.pend && tick && q.cnt < lim && !ctl_wr // R1
      |=> q.cnt == $past(q.cnt) + 15'h0001)
      else $error("counter step wrong");

   // Terminal count minus one for each interval code
   AST_LIM_CODE: assert property ((q.intv != 2'b11 || lim == 15'd63) // R7
      && (q.intv != 2'b10 || lim == 15'd511) && (q.intv != 2'b01 || lim == 15'd8191)
      && (q.intv != 2'b00 || lim == 15'd32767))
      else $error("interval code gives wrong terminal count");

   // Timer function: key bit 0 zeroes the counter
   AST_TMR_CLR: assert property (ctl_wr && q.en && q.mode && nib[0] |=> q.cnt == 15'h0000) // R16
      else $error("timer clear bit ignored");

   // Run bit set from stopped starts at zero
   AST_TMR_RESTART: assert property (ctl_wr && !q.en && wbyte[`WIT_EN_BIT] // R17
      |=> q.en && q.cnt == 15'h0000)
      else $error("restart not from zero");

   // Timer function: run bit 0 halts
   AST_TMR_STOP: assert property (ctl_wr && q.mode && !wbyte[`WIT_EN_BIT] |=> !q.en) // R17
      else $error("timer did not stop");

   // First key on a running watchdog arms the pair
   AST_KEY_ARM: assert property (ctl_wr && wd_run && nib == 4'hA && !q.pend // R9
      |=> q.key == WIT_KEY_ARMED)
      else $error("first key did not arm");

   // Armed pair lapses when its window runs out
   AST_KEY_TIMEOUT: assert property (q.key == WIT_KEY_ARMED && q.ktmr == 12'h000 // R10
      && !ctl_wr |=> q.key == WIT_KEY_IDLE)
      else $error("key window did not lapse");

   // Any other nibble leaves no pair armed
   AST_KEY_WRONG: assert property (ctl_wr && wd_run && nib != 4'hA // R10
      && !(q.key == WIT_KEY_ARMED && nib == 4'h5) |=> q.key == WIT_KEY_IDLE)
      else $error("wrong key left pair armed");

   // Interval field takes every write made with no expiry pending
   AST_INTV_WRITE: assert property (ctl_wr && !q.pend |=> q.intv == $past(wbyte[1:0])) // R12
      else $error("interval write lost");

   // Armed pair keeps a pending watchdog running
   AST_PEND_HELD: assert property (q.pend && q.key == WIT_KEY_ARMED |=> q.en) // R11
      else $error("watchdog expired during key pair");

   // Watchdog cause stays until power-on reset
   AST_CAUSE_HOLD: assert property (RST_CAUSE == 2'b10 |=> RST_CAUSE == 2'b10) // R21
      else $error("reset cause lost");

   // Timer function never holds a pending expiry
   AST_TMR_NO_PEND: assert property (q.mode |-> !q.pend) // R18
      else $error("expiry pending in timer function");

   // Interrupt is a single-cycle pulse
   AST_IRQ_PULSE: assert property (TIMER_IRQ |=> !TIMER_IRQ) // R15
      else $error("interrupt wider than one cycle");

   // Control readback shows run, function and interval
   AST_CTL_READBACK: assert property (q.rd_done && $past(ADDRESS) == `WIT_CTL_ADDR // R3
      |-> READDATA[3:0] == {$past(q.en), $past(q.mode), $past(q.intv)})
      else $error("control readback wrong");

   // A read stalls for exactly one cycle
   AST_RD_ONE_WAIT: assert property (READ && WAITREQUEST |=> !WAITREQUEST) // R20
      else $error("read stalled too long");

endmodule

// ### test/wit_top_tb.sv
`timescale 1ns/100ps
`include "wit_defines.svh"
module wit_top_tb;
   import wit_pkg::*;
   // ****************************************************************
   // Stimulus and observation
   // ****************************************************************
   logic clk = 1'b0;
   logic nrst = 1'b0;
   wit_addr_t address = 12'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic sys_rst_req;
   logic timer_irq;
   logic [1:0] rst_cause;
   logic wd_mode = 1'b0;
   logic rst_seen = 1'b0;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   int t0;
   int lim;
   logic [1:0] code;
   wit_addr_t ua;

   // Short slow tick and key window keep the run brief
   always #25 clk = ~clk;

   wit_top #(.SLOW_DIV(8), .KEY_WIN(3), .RST_PULSE(4)) u_dut (.CLK(clk), .NRST(nrst),
      .ADDRESS(address), .READ(read), .WRITE(write), .WRITEDATA(writedata),
      .READDATA(readdata), .WAITREQUEST(waitrequest), .SYS_RST_REQ(sys_rst_req),
      .TIMER_IRQ(timer_irq), .RST_CAUSE(rst_cause));

   // ****************************************************************
   // Compare and bus tasks
   // ****************************************************************
   task final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t value %h expected %h", $time, got, exp);
      end
   endtask

   // Cycle gaps are bench counts, never unknown
   task chk_gap(input int got, input int lo, input int hi);
      num_checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("BAD t=%0t gap %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task wr(input wit_addr_t a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      writedata <= {24'h00_0000, d};
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask

   task rd(input wit_addr_t a, input logic [31:0] exp);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      chk(readdata, exp);
   endtask

   // Key pair back to back, keeping the run bit and watchdog function
   task kclear(input logic [1:0] iv);
      wr(`WIT_CTL_ADDR, {4'hA, 2'b10, iv});
      wr(`WIT_CTL_ADDR, {4'h5, 2'b10, iv});
   endtask

   // The interrupt pulse is one cycle wide, so every edge is looked at
   task wait_ev(input int lm, input logic rst_ev, output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((rst_ev ? sys_rst_req : timer_irq) !== 1'b1 && k < lm);
   endtask

   // ****************************************************************
   // Function-dependent output watch
   // ****************************************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sys_rst_req === 1'b1)
         rst_seen <= 1'b1;
      if (wd_mode === 1'b1)
         chk({31'h0, timer_irq}, 32'h0);
      else
         chk({31'h0, sys_rst_req}, 32'h0);
   end

   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      final_report();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'hd3e8));
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(`WIT_CTL_ADDR, 32'h0);
      rd(`WIT_STAT_ADDR, 32'h0);
      // Stopped timer: key bits ignored and never read back
      wr(`WIT_CTL_ADDR, {4'($urandom), 4'h7});
      rd(`WIT_CTL_ADDR, 32'h07);
      wait_ev(600, 1'b0, n);
      chk_gap(n, 600, 600);
      // Interval timer at the two shortest intervals
      for (int c = 3; c >= 2; c--) begin
         code = 2'(c);
         lim = (c == 3) ? 64 * 8 : 512 * 8;
         wr(`WIT_CTL_ADDR, {4'h0, 2'b11, code});
         wait_ev(lim + 50, 1'b0, n);
         chk_gap(n, lim - 16, lim + 16);
         wait_ev(lim + 50, 1'b0, n);
         chk_gap(n, lim, lim);
         wr(`WIT_CTL_ADDR, {4'h0, 2'b01, code});
      end
      wr(`WIT_CTL_ADDR, 8'h0F);
      repeat (300) @(posedge clk);
      wr(`WIT_CTL_ADDR, 8'h1F);
      wait_ev(600, 1'b0, n);
      chk_gap(n, 496, 520);
      repeat (300) @(posedge clk);
      wr(`WIT_CTL_ADDR, 8'h07);
      wait_ev(200, 1'b0, n);
      chk_gap(n, 200, 200);
      wr(`WIT_CTL_ADDR, 8'h0F);
      wait_ev(600, 1'b0, n);
      chk_gap(n, 496, 520);
      wr(`WIT_CTL_ADDR, 8'h07);
      // Watchdog: locked function and run bit
      wd_mode <= 1'b1;
      wr(`WIT_CTL_ADDR, 8'h03);
      wr(`WIT_CTL_ADDR, 8'h0B);
      wr(`WIT_CTL_ADDR, 8'h07);
      rd(`WIT_CTL_ADDR, 32'h0B);
      for (int i = 0; i < 3; i++) begin
         repeat (400) @(posedge clk);
         kclear(2'b11);
      end
      chk({31'h0, rst_seen}, 32'h0);
      kclear(2'b10);
      rd(`WIT_CTL_ADDR, 32'h0A);
      repeat (700) @(posedge clk);
      chk({31'h0, rst_seen}, 32'h0);
      kclear(2'b11);
      t0 = cyc;
      // Second key far outside the window must not reload
      repeat (100) @(posedge clk);
      wr(`WIT_CTL_ADDR, 8'hAB);
      repeat (10) @(posedge clk);
      wr(`WIT_CTL_ADDR, 8'h5B);
      wait_ev(600, 1'b1, n);
      chk_gap(cyc - t0, 500, 530);
      repeat (6) @(posedge clk);
      chk({30'h0, rst_cause}, 32'h2);
      rd(`WIT_STAT_ADDR, 32'h2);
      rd(`WIT_CTL_ADDR, 32'h0);
      wd_mode <= 1'b0;
      // Unmapped places hold nothing, counter stays hidden
      for (int i = 0; i < 4; i++) begin
         ua = {2'b00, 8'($urandom_range(0, 200)), 2'b00};
         wr(ua, 8'($urandom));
         rd(ua, 32'h0);
         rd(`WIT_CTL_ADDR, 32'h0);
      end
      final_report();
   end
endmodule
